/* core/cstu_top.sv */
// clock source selection, dividers and tick counters
`timescale 1ns/10ps
// Contract
// - 13-bit central counter advances on each 1 kHz tick.
// - central counter runs except in hibernate or debug halt.
// - central counter gives periodic interrupt and low-power wake.
// - firmware reset clears central counter, counting then resumes.
// - 5-bit fast counter at 100 kHz wraps at programmable terminal count.
// - fast counter interrupts at terminal count when enabled.
// - low-speed oscillator supplies 1, 33 and 100 kHz clocks.
// - 33 kHz clock is 100 kHz divided by three.
// - main oscillator selects 3, 6, 12, 24, 48 or 62 MHz.
// - doubler gives twice its input frequency.
// - PLL input from main osc, fast crystal or logic block.
// - PLL 24 to 67 MHz, input and feedback dividers give ratios.
// - PLL locks within 250 us, sets lock bit; source usable meanwhile.
// - lock indication routable to interconnect for an interrupt.
// - divided outputs have 50% duty; direct routes need not. The digital and analog dividers give 50% for even divide values only.
// - eight digital and four analog 16-bit dividers, own source each.
// - 16-bit bus clock divider followed by 4-bit CPU divider.
// - eight extra interconnect clocks route into digital dividers.
// - main oscillator USB mode locks to bus timing.
// - watch crystal feeds sleep timer, gives one-second interrupt.
// - dividers pick one of eight inputs, divide by two or more.
module cstu_top import cstu_pkg::*; (
   input wire logic core_clk, // master clock, 100 MHz
   input wire logic reset, // synchronous, active high
   input wire logic main_internal_osc, // main oscillator clock pin
   input wire logic fast_crystal_osc, // fast crystal clock pin
   input wire logic watch_crystal_osc_32k, // watch crystal clock pin
   input wire logic fast_low_power_clock, // 100 kHz low-speed clock pin
   input wire logic slow_tick_clock, // 1 kHz low-speed clock pin
   input wire logic universal_logic_block, // primary interconnect clock
   input wire logic [7:0] ulb_div_clk, // extra interconnect clocks
   input wire logic hibernate, // device in hibernate
   input wire logic debug_halt, // cpu halted by debugger
   input wire logic ctw_clear, // firmware counter reset
   input wire logic [12:0] ctw_period_mask, // periodic interrupt mask
   input wire logic [4:0] ftw_terminal, // fast counter terminal count
   input wire logic ftw_int_en, // fast counter interrupt enable
   input wire logic [2:0] imo_freq_sel, // main osc frequency select
   input wire logic imo_usb_mode, // main osc usb lock mode
   input wire logic usb_sof, // usb frame timing pulse
   input wire logic pll_enable, // pll enable
   input wire logic [1:0] pll_src_sel, // pll input select
   input wire logic [5:0] pll_p_div, // pll feedback divider
   input wire logic [5:0] pll_q_div, // pll input divider
   input wire logic dbl_enable, // doubler enable
   input wire logic [2:0] div_src [CSTU_NDIV], // per-divider source
   input wire logic [15:0] div_val [CSTU_NDIV], // per-divider divide value
   input wire logic [2:0] bus_src, // bus divider source
   input wire logic [15:0] bus_div_val, // bus divide value
   input wire logic [3:0] cpu_div_val, // cpu divide value
   output logic [12:0] ctw_count, // central tick count
   output logic ctw_irq, // central periodic interrupt pulse
   output logic ctw_wake, // central wake pulse
   output logic [4:0] ftw_count, // fast tick count
   output logic ftw_irq, // fast terminal count pulse
   output logic third_rate_low_clock, // 33 kHz clock
   output logic slow_tick_out, // 1 kHz clock, direct route
   output logic fast_low_out, // 100 kHz clock, direct route
   output logic [2:0] imo_freq, // selected main osc setting
   output logic imo_usb_locked, // main osc locked to usb timing
   output logic dbl_active, // doubler running
   output logic pll_locked, // pll lock status bit
   output logic pll_lock_ulb, // lock routed to interconnect
   output logic pll_src_clk, // pll reference, usable before lock
   output logic [11:0] pll_ratio, // pll divider pair
   output logic rtc_sec_irq, // one-second pulse
   output logic sleep_tick, // watch crystal tick to sleep timer
   output logic [CSTU_NDIV-1:0] div_clk, // divided clocks
   output logic bus_clk, // bus clock
   output logic cpu_clk // cpu clock
);
   // two-flop synchronisers for all pin clocks
   localparam int NSYNC = 15;
   logic [NSYNC-1:0] pin_raw, s1_q, s2_q, s3_q;
   assign pin_raw = {ulb_div_clk, usb_sof, universal_logic_block, watch_crystal_osc_32k,
                     fast_low_power_clock, slow_tick_clock, fast_crystal_osc,
                     main_internal_osc};
   always_ff @(posedge core_clk) begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
   end
   // rising edges seen in the first cycle the second flop is high
   logic [NSYNC-1:0] rise;
   assign rise = s2_q & ~s3_q;
   // synchronised levels and edges by source
   wire imo_s = s2_q[0];
   wire xtal_s = s2_q[1];
   wire tick1k = rise[2];
   wire tick100k = rise[3];
   wire tick32k = rise[4];
   wire ulb_s = s2_q[5];
   wire sof = rise[6];
   wire [7:0] ulb_x = s2_q[14:7];

   // central tick counter
   logic [12:0] ctw_q, ctw_d;
   logic ctw_irq_q, ctw_wake_q;
   wire ctw_run = ~hibernate & ~debug_halt;
   assign ctw_d = ctw_clear ? 13'h0000 : (ctw_run & tick1k) ? ctw_q + 13'h0001 : ctw_q;
   wire [12:0] ctw_next = ctw_q + 13'h0001;
   wire ctw_step = ctw_run & tick1k & ~ctw_clear;
   // periodic pulse when the new count has every masked bit clear
   wire ctw_hit = ctw_step & ((ctw_next & ctw_period_mask) == 13'h0000);
   always_ff @(posedge core_clk) begin
      if (reset) begin
         ctw_q <= 13'h0000;
         ctw_irq_q <= 1'b0;
         ctw_wake_q <= 1'b0;
      end else begin
         ctw_q <= ctw_d;
         ctw_irq_q <= ctw_hit;
         ctw_wake_q <= ctw_hit;
      end
   end

   // fast tick counter
   logic [4:0] ftw_q;
   logic ftw_irq_q;
   wire ftw_tc = tick100k & (ftw_q == ftw_terminal);
   // next count and interrupt pulse
   wire [4:0] ftw_d = ftw_tc ? 5'h00 : tick100k ? ftw_q + 5'h01 : ftw_q;
   wire ftw_pulse = ftw_tc & ftw_int_en;
   always_ff @(posedge core_clk) begin
      if (reset) begin
         ftw_q <= 5'h00;
         ftw_irq_q <= 1'b0;
      end else begin
         ftw_q <= ftw_d;
         ftw_irq_q <= ftw_pulse;
      end
   end

   // 33 kHz from 100 kHz by three, low-speed direct routes
   // toggling on every third edge of either polarity keeps the duty at 50%
   logic [1:0] third_q;
   logic third_clk_q, slow_q, fast_q;
   wire fall100k = ~s2_q[3] & s3_q[3];
   wire edge100k = tick100k | fall100k;
   wire third_turn = third_q == CSTU_THIRD_LAST;
   always_ff @(posedge core_clk) begin
      if (reset) begin
         third_q <= 2'h0;
         third_clk_q <= 1'b0;
         slow_q <= 1'b0;
         fast_q <= 1'b0;
      end else begin
         if (edge100k) begin
            third_q <= third_turn ? 2'h0 : third_q + 2'h1;
            if (third_turn) third_clk_q <= ~third_clk_q;
         end
         slow_q <= s2_q[2];
         fast_q <= s2_q[3];
      end
   end

   // main oscillator setting, usb lock, doubler
   logic [2:0] imo_q;
   logic usb_lock_q, dbl_q;
   wire imo_ok = imo_freq_sel <= CSTU_IMO_62;
   // usb lock holds while the mode stays on
   wire usb_lock_d = imo_usb_mode & (usb_lock_q | sof);
   always_ff @(posedge core_clk) begin
      if (reset) begin
         imo_q <= CSTU_IMO_3;
         usb_lock_q <= 1'b0;
         dbl_q <= 1'b0;
      end else begin
         if (imo_ok) imo_q <= imo_freq_sel;
         usb_lock_q <= usb_lock_d;
         dbl_q <= dbl_enable;
      end
   end

   // pll reference select and lock timer
   cstu_pll_t pll_q, pll_d;
   logic [14:0] lock_cnt_q;
   logic lock_q, ref_q;
   logic [11:0] ratio_q;
   wire lock_done = lock_cnt_q == 15'(CSTU_PLL_LOCK_CYC - 1);
   wire pll_wait = pll_q == CSTU_PLL_WAIT;
   // lock timer runs only while waiting, status follows the next state
   wire [14:0] lock_cnt_d = pll_wait ? lock_cnt_q + 15'h0001 : 15'h0000;
   wire lock_d = pll_d == CSTU_PLL_LOCKED;
   wire pll_ref = (pll_src_sel == CSTU_PLL_SRC_XTAL) ? xtal_s :
                  (pll_src_sel == CSTU_PLL_SRC_ULB) ? ulb_s : imo_s;
   always_comb begin
      pll_d = pll_q;
      case (pll_q)
         CSTU_PLL_OFF: if (pll_enable) pll_d = CSTU_PLL_WAIT;
         CSTU_PLL_WAIT: if (!pll_enable) pll_d = CSTU_PLL_OFF;
                        else if (lock_done) pll_d = CSTU_PLL_LOCKED;
         CSTU_PLL_LOCKED: if (!pll_enable) pll_d = CSTU_PLL_OFF;
         default: pll_d = CSTU_PLL_OFF;
      endcase
   end
   always_ff @(posedge core_clk) begin
      if (reset) begin
         pll_q <= CSTU_PLL_OFF;
         lock_cnt_q <= 15'h0000;
         lock_q <= 1'b0;
         ref_q <= 1'b0;
         ratio_q <= 12'h000;
      end else begin
         pll_q <= pll_d;
         lock_cnt_q <= lock_cnt_d;
         lock_q <= lock_d;
         ref_q <= pll_ref;
         ratio_q <= {pll_p_div, pll_q_div};
      end
   end

   // watch crystal second tick
   logic [14:0] sec_q;
   logic sec_irq_q, sleep_q;
   // pulse on the last watch tick of each second
   wire sec_last = tick32k & (sec_q == CSTU_SEC_LAST);
   always_ff @(posedge core_clk) begin
      if (reset) begin
         sec_q <= 15'h0000;
         sec_irq_q <= 1'b0;
         sleep_q <= 1'b0;
      end else begin
         if (tick32k) sec_q <= sec_q + 15'h0001;
         sec_irq_q <= sec_last;
         sleep_q <= tick32k;
      end
   end

   // shared source set for the dividers
   logic [7:0] src_bus;
   assign src_bus = {third_clk_q, s2_q[3], s2_q[2], s2_q[4], pll_ref, ulb_s, xtal_s, imo_s};

   // digital and analog dividers
   logic [CSTU_NDIV-1:0] div_clk_q;
   genvar g;
   generate
      for (g = 0; g < CSTU_NDIV; g++) begin : g_div
         logic [7:0] srcs;
         logic src_q;
         logic [15:0] cnt_q;
         // a divide value under two is raised to two
         wire [15:0] lim = (div_val[g] < CSTU_DIV_MIN) ? CSTU_DIV_MIN : div_val[g];
         // digital dividers may take a dedicated interconnect clock on input 2
         if (g < CSTU_NDIG) begin : g_dig
            assign srcs = {src_bus[7:3], ulb_x[g], src_bus[1:0]};
         end else begin : g_ana
            assign srcs = src_bus;
         end
         // named terms keep the divider process short
         logic sel_in, div_wrap, div_hi;
         logic [15:0] lim_m1, cnt_p1;
         assign sel_in = srcs[div_src[g]];
         assign lim_m1 = lim - 16'h0001;
         assign cnt_p1 = cnt_q + 16'h0001;
         assign div_wrap = cnt_q >= lim_m1;
         assign div_hi = ~div_wrap & (cnt_p1 >= (lim >> 1));
         wire edge_in = sel_in & ~src_q;
         always_ff @(posedge core_clk) begin
            if (reset) begin
               src_q <= 1'b0;
               cnt_q <= 16'h0000;
               div_clk_q[g] <= 1'b0;
            end else begin
               src_q <= sel_in;
               if (edge_in) begin
                  cnt_q <= div_wrap ? 16'h0000 : cnt_p1;
                  div_clk_q[g] <= div_hi;
               end
            end
         end
      end
   endgenerate

   // bus divider on master clock path, cpu divider after it
   logic [15:0] bus_cnt_q;
   logic bus_q, bus_src_q, cpu_q;
   logic [3:0] cpu_cnt_q;
   wire bus_in = src_bus[bus_src];
   wire bus_edge = bus_in & ~bus_src_q;
   wire bus_wrap = bus_cnt_q >= bus_div_val;
   // cpu divider counts bus clock rising edges
   wire bus_rise = bus_edge & bus_wrap & ~bus_q;
   wire cpu_wrap = cpu_cnt_q >= cpu_div_val;
   // next counts for the two chained dividers
   wire [15:0] bus_cnt_d = bus_wrap ? 16'h0000 : bus_cnt_q + 16'h0001;
   wire [3:0] cpu_cnt_d = cpu_wrap ? 4'h0 : cpu_cnt_q + 4'h1;
   always_ff @(posedge core_clk) begin
      if (reset) begin
         bus_cnt_q <= 16'h0000;
         bus_q <= 1'b0;
         bus_src_q <= 1'b0;
         cpu_cnt_q <= 4'h0;
         cpu_q <= 1'b0;
      end else begin
         bus_src_q <= bus_in;
         if (bus_edge) begin
            bus_cnt_q <= bus_cnt_d;
            if (bus_wrap) bus_q <= ~bus_q;
         end
         if (bus_rise) begin
            cpu_cnt_q <= cpu_cnt_d;
            if (cpu_wrap) cpu_q <= ~cpu_q;
         end
      end
   end

   // tick counter outputs
   assign ctw_count = ctw_q;
   assign ctw_irq = ctw_irq_q;
   assign ctw_wake = ctw_wake_q;
   assign ftw_count = ftw_q;
   assign ftw_irq = ftw_irq_q;

   // low-speed clocks
   assign third_rate_low_clock = third_clk_q;
   assign slow_tick_out = slow_q;
   assign fast_low_out = fast_q;

   // main oscillator and doubler status
   assign imo_freq = imo_q;
   assign imo_usb_locked = usb_lock_q;
   assign dbl_active = dbl_q;

   // pll status and reference
   assign pll_locked = lock_q;
   assign pll_lock_ulb = lock_q;
   assign pll_src_clk = ref_q;
   assign pll_ratio = ratio_q;

   // watch crystal pulses
   assign rtc_sec_irq = sec_irq_q;
   assign sleep_tick = sleep_q;

   // divided clocks
   assign div_clk = div_clk_q;
   assign bus_clk = bus_q;
   assign cpu_clk = cpu_q;
endmodule // cstu_top

/* core/cstu_pkg.sv */
// constants for the clock source and timewheel unit
package cstu_pkg;
   localparam int CSTU_CLK_MHZ = 100;
   localparam int CSTU_PLL_LOCK_US = 250;
   localparam int CSTU_PLL_LOCK_CYC = CSTU_PLL_LOCK_US * CSTU_CLK_MHZ;
   localparam int CSTU_CTW_W = 13;
   localparam int CSTU_FTW_W = 5;
   localparam int CSTU_DIV_W = 16;
   localparam int CSTU_CPU_DIV_W = 4;
   localparam int CSTU_NDIG = 8;
   localparam int CSTU_NANA = 4;
   localparam int CSTU_NDIV = 12;
   localparam int CSTU_SEC_W = 15;
   localparam logic [14:0] CSTU_SEC_LAST = 15'h7FFF;
   localparam logic [1:0] CSTU_THIRD_LAST = 2'h2;
   localparam logic [2:0] CSTU_IMO_3 = 3'h0;
   localparam logic [2:0] CSTU_IMO_62 = 3'h5;
   localparam logic [1:0] CSTU_PLL_SRC_IMO = 2'h0;
   localparam logic [1:0] CSTU_PLL_SRC_XTAL = 2'h1;
   localparam logic [1:0] CSTU_PLL_SRC_ULB = 2'h2;
   localparam logic [15:0] CSTU_DIV_MIN = 16'h0002;
   typedef enum logic [2:0] {
      CSTU_PLL_OFF = 3'b001,
      CSTU_PLL_WAIT = 3'b010,
      CSTU_PLL_LOCKED = 3'b100
   } cstu_pll_t;
endpackage

/* sim/cstu_top_asserts.sv */
// assertions on the clock source and timewheel unit ports
`timescale 1ns/10ps
module cstu_top_asserts (
   input wire logic core_clk, // clock
   input wire logic reset, // reset
   input wire logic hibernate, // hold
   input wire logic debug_halt, // hold
   input wire logic ctw_clear, // clear
   input wire logic [12:0] ctw_period_mask, // mask
   input wire logic [4:0] ftw_terminal, // terminal
   input wire logic ftw_int_en, // enable
   input wire logic [2:0] imo_freq_sel, // select
   input wire logic pll_enable, // enable
   input wire logic [12:0] ctw_count, // count
   input wire logic ctw_irq, // pulse
   input wire logic ctw_wake, // pulse
   input wire logic [4:0] ftw_count, // count
   input wire logic ftw_irq, // pulse
   input wire logic [2:0] imo_freq, // setting
   input wire logic pll_locked // status
);
   // one domain, reset disables every check
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);
   // central counter steps, holds and clears
   a_ctw_step_one: assert property ($changed(ctw_count) |->
      ctw_count == 13'h0000 || ctw_count == $past(ctw_count) + 13'h0001) else $error("count jumped");
   a_ctw_hold_off: assert property ((hibernate || debug_halt) && !ctw_clear |=>
      $stable(ctw_count)) else $error("central count moved while held");
   a_ctw_clear_zero: assert property (ctw_clear |=> ctw_count == 13'h0000)
      else $error("central count not cleared");
   a_ctw_irq_mask: assert property (ctw_irq |->
      (ctw_count & $past(ctw_period_mask)) == 13'h0000) else $error("periodic pulse off mask");
   a_ctw_wake_pair: assert property (ctw_wake == ctw_irq)
      else $error("wake and periodic pulse differ");
   // fast counter wrap and pulse
   a_ftw_wrap_zero: assert property ($changed(ftw_count) && $past(ftw_count) == $past(ftw_terminal) |->
      ftw_count == 5'h00) else $error("fast count missed wrap");
   a_ftw_irq_cause: assert property (ftw_irq |-> ftw_count == 5'h00 && $past(ftw_int_en))
      else $error("fast pulse without cause");
   a_ftw_irq_due: assert property ($changed(ftw_count) && $past(ftw_count) == $past(ftw_terminal) &&
      $past(ftw_int_en) |-> ftw_irq) else $error("fast pulse missing");
   // main oscillator setting
   a_imo_take_sel: assert property (imo_freq_sel <= 3'h5 |=> imo_freq == $past(imo_freq_sel))
      else $error("setting not taken");
   a_imo_refuse_sel: assert property (imo_freq_sel > 3'h5 |=> $stable(imo_freq))
      else $error("illegal setting taken");
   // lock status
   a_pll_off_clear: assert property (!pll_enable |=> !pll_locked)
      else $error("lock shown while disabled");
   a_pll_no_early: assert property ($rose(pll_enable) |=> !pll_locked [*8])
      else $error("lock shown at once");
   c_ftw_irq: cover property (ftw_irq);
   c_ctw_irq: cover property (ctw_irq);
   c_pll_lock: cover property ($rose(pll_locked));
endmodule // cstu_top_asserts
bind cstu_top cstu_top_asserts u_chk (.core_clk(core_clk), .reset(reset), .hibernate(hibernate),
   .debug_halt(debug_halt), .ctw_clear(ctw_clear), .ctw_period_mask(ctw_period_mask),
   .ftw_terminal(ftw_terminal), .ftw_int_en(ftw_int_en), .imo_freq_sel(imo_freq_sel),
   .pll_enable(pll_enable), .ctw_count(ctw_count), .ctw_irq(ctw_irq), .ctw_wake(ctw_wake),
   .ftw_count(ftw_count), .ftw_irq(ftw_irq), .imo_freq(imo_freq), .pll_locked(pll_locked));

/* sim/cstu_osc_model.sv */
// oscillator pins seen by the unit, scaled up in rate
`timescale 1ns/10ps
module cstu_osc_model #(parameter int FAST_NS = 200, parameter int SLOW_NS = 1000) (
   output logic fast_low_power_clock, // fast low clock
   output logic slow_tick_clock, // slow tick clock
   output logic [11:0] misc_osc // other pin clocks
);
   // oscillators run free, no framing
   initial begin
      fast_low_power_clock = 1'b0;
      forever #(FAST_NS / 2) fast_low_power_clock = ~fast_low_power_clock;
   end
   initial begin
      slow_tick_clock = 1'b0;
      forever #(SLOW_NS / 2) slow_tick_clock = ~slow_tick_clock;
   end
   initial begin
      misc_osc = 12'hA5C;
      forever #35 misc_osc = {misc_osc[10:0], ~misc_osc[11]};
   end
endmodule // cstu_osc_model

/* sim/tb_clock_source_and_timewheel_unit.sv */
// self-checking bench for the clock source and timewheel unit
`timescale 1ns/10ps
module tb_clock_source_and_timewheel_unit import cstu_pkg::*;;
   logic core_clk, reset, hibernate, debug_halt, ctw_clear, ftw_int_en, pll_enable, dbl_enable;
   logic [12:0] ctw_period_mask;
   logic [4:0] ftw_terminal;
   logic [2:0] imo_freq_sel, bus_src;
   logic [5:0] pll_p_div, pll_q_div;
   logic [1:0] pll_src_sel;
   logic [2:0] div_src [CSTU_NDIV];
   logic [15:0] div_val [CSTU_NDIV];
   logic [15:0] bus_div_val;
   logic [3:0] cpu_div_val;
   wire logic fast_low_power_clock, slow_tick_clock, ctw_irq, ctw_wake, ftw_irq, pll_locked;
   wire logic third_rate_low_clock, pll_lock_ulb, bus_clk, cpu_clk;
   wire logic slow_tick_out, fast_low_out, imo_usb_locked, dbl_active, rtc_sec_irq, sleep_tick;
   wire logic [11:0] pll_ratio;
   wire logic [11:0] misc_osc, div_clk;
   wire logic [12:0] ctw_count;
   wire logic [4:0] ftw_count;
   wire logic [2:0] imo_freq;
   int err_total, comparisons, ctw_n, ftw_n, sl_n, i, s, p, h, n, e, v, dk;
   wire logic [3:0] probe = {cpu_clk, bus_clk, third_rate_low_clock, div_clk[dk]};
   cstu_osc_model u_osc (.fast_low_power_clock, .slow_tick_clock, .misc_osc);
   cstu_top dut (.core_clk, .reset, .main_internal_osc(misc_osc[0]), .fast_crystal_osc(misc_osc[1]),
      .watch_crystal_osc_32k(misc_osc[2]), .fast_low_power_clock, .slow_tick_clock,
      .universal_logic_block(misc_osc[3]), .ulb_div_clk({misc_osc[11:5], misc_osc[0]}),
      .hibernate, .debug_halt, .ctw_clear, .ctw_period_mask, .ftw_terminal, .ftw_int_en,
      .imo_freq_sel, .imo_usb_mode(dbl_enable), .usb_sof(misc_osc[4]), .pll_enable, .pll_src_sel,
      .pll_p_div, .pll_q_div, .dbl_enable, .div_src, .div_val, .bus_src, .bus_div_val, .cpu_div_val,
      .ctw_count, .ctw_irq, .ctw_wake, .ftw_count, .ftw_irq, .third_rate_low_clock, .slow_tick_out,
      .fast_low_out, .imo_freq, .imo_usb_locked, .dbl_active, .pll_locked, .pll_lock_ulb,
      .pll_src_clk(), .pll_ratio, .rtc_sec_irq, .sleep_tick, .div_clk, .bus_clk, .cpu_clk);
   // clock and pulse counters
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      ctw_n += (ctw_irq === 1'b1);
      ftw_n += (ftw_irq === 1'b1);
      sl_n += (sleep_tick === 1'b1);
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge core_clk);
   endtask
   // wait k pin ticks, then let the synchroniser settle
   task automatic tick(input bit slow, input int k);
      repeat (k) @(posedge (slow ? slow_tick_clock : fast_low_power_clock));
      cyc(10);
   endtask
   // high time and period of one probed clock
   task automatic per(input int j);
      h = 0;
      while (probe[j] === 1'b1 && h < 20000) begin cyc(1); h++; end
      while (probe[j] !== 1'b1 && h < 40000) begin cyc(1); h++; end
      h = 0;
      while (probe[j] === 1'b1 && h < 20000) begin cyc(1); h++; end
      p = h;
      while (probe[j] !== 1'b1 && p < 20000) begin cyc(1); p++; end
   endtask
   task automatic wrap_up;
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #700_000;
      err_total++;
      wrap_up;
   end
   initial begin
      void'($urandom(32'hB9B6));
      {hibernate, debug_halt, ctw_clear, ftw_int_en, pll_enable, dk} = '0;
      {ctw_period_mask, ftw_terminal, imo_freq_sel, cpu_div_val} = '0;
      dbl_enable = 1'($urandom);
      pll_src_sel = 2'($urandom_range(0, 2));
      {pll_p_div, pll_q_div} = 12'($urandom);
      bus_src = 3'h6;
      bus_div_val = 16'h0000;
      for (i = 0; i < CSTU_NDIV; i++) begin
         div_src[i] = 3'($urandom);
         div_val[i] = 16'($urandom_range(2, 9));
      end
      reset = 1'b1;
      cyc(4);
      reset <= 1'b0;
      cyc(1);
      chk(ctw_count, 0);
      chk(pll_locked, 0);
      // central counter: clear, count, periodic pulse, holds
      ctw_period_mask <= 13'h0003;
      tick(1, 1);
      chk(slow_tick_out, 1);
      ctw_clear <= 1'b1;
      cyc(1);
      ctw_clear <= 1'b0;
      cyc(1);
      chk(ctw_count, 0);
      ctw_n = 0;
      tick(1, 8);
      chk(ctw_count, 8);
      chk(ctw_n, 2);
      for (i = 0; i < 2; i++) begin
         hibernate <= (i == 0);
         debug_halt <= (i == 1);
         cyc(1);
         s = ctw_count;
         tick(1, 3);
         chk(ctw_count, s);
         {hibernate, debug_halt} <= 2'b00;
         tick(1, 2);
         chk(ctw_count, s + 2);
      end
      // fast counter: top, zero, random terminals, pulse off
      for (i = 0; i < 4; i++) begin
         e = (i == 0) ? 31 : (i == 1) ? 0 : $urandom_range(1, 30);
         ftw_terminal <= 5'(e);
         ftw_int_en <= (i != 3);
         tick(0, 33);
         chk(fast_low_out, 1);
         s = ftw_count;
         ftw_n = 0;
         tick(0, 3 * (e + 1));
         chk(ftw_count, s);
         chk(ftw_n, (i != 3) ? 3 : 0);
      end
      // main oscillator codes, refused ones interleaved
      e = 0;
      for (i = 0; i < 8; i++) begin
         imo_freq_sel <= 3'((i * 5) % 8);
         e = ((i * 5) % 8 <= 5) ? (i * 5) % 8 : e;
         cyc(3);
         chk(imo_freq, e);
      end
      // third-rate clock and dividers fed from the fast low clock
      per(1);
      chk(p, 60);
      chk(h * 2, p);
      for (i = 0; i < 2; i++) begin
         dk = $urandom_range(0, CSTU_NDIV - 1);
         v = 2 * $urandom_range(1, 3);
         div_src[dk] <= 3'h6;
         div_val[dk] <= 16'(v);
         tick(0, 2 * v);
         per(0);
         chk(p, v * 20);
         chk(h * 2, p);
      end
      v = $urandom_range(0, 2);
      e = $urandom_range(0, 2);
      bus_div_val <= 16'(v);
      cpu_div_val <= 4'(e);
      tick(0, 40);
      per(2);
      chk(p, 40 * (v + 1));
      per(3);
      chk(p, 80 * (v + 1) * (e + 1));
      // lock after the documented wait, cleared on disable
      pll_enable <= 1'b1;
      n = 0;
      while (pll_locked !== 1'b1 && n < 30000) begin cyc(1); n++; end
      chk(n >= CSTU_PLL_LOCK_CYC && n <= CSTU_PLL_LOCK_CYC + 5, 1);
      cyc(4);
      chk(pll_lock_ulb, 1);
      pll_enable <= 1'b0;
      cyc(3);
      chk(pll_locked, 0);
      chk(pll_ratio, {pll_p_div, pll_q_div});
      chk(dbl_active, dbl_enable);
      chk(imo_usb_locked, dbl_enable);
      chk(sl_n != 0, 1);
      chk(rtc_sec_irq, 0);
      wrap_up;
   end
endmodule // tb_clock_source_and_timewheel_unit
